// File: core/dip_ctrl.sv
// delivery unit with its own interrupt source group and a link to one
// external source unit.
// assumes the access port and the external link run on i_core_clk,
// and the interrupt lines come from pins on no known clock.
`timescale 1ns/1ps

module dip_ctrl
   import dip_pkg::*;
#(
   parameter int unsigned N_SRC = 16,                 // group size
   parameter logic [7:0] GRP_FIRST = 8'h00,           // lowest number
   parameter int unsigned N_CPU = 32,                 // processors
   parameter logic [31:0] DU_BASE = 32'hFC00_0000,    // unit base
   parameter logic [31:0] DU_SIZE = 32'h0004_0000     // window length
) (
   input wire logic i_core_clk,                  // core clock
   input wire logic i_rst,                       // sync reset, high
   input wire logic [N_SRC-1:0] i_irq_lines,     // source pins
   input wire logic i_acc_valid,                 // access strobe
   input wire logic i_acc_write,                 // 1 write, 0 read
   input wire logic [31:0] i_acc_addr,           // byte address
   input wire logic [31:0] i_acc_wdata,          // write data, LE
   output logic o_acc_ack,                       // access answered
   output logic o_acc_err,                       // misaligned slot
   output logic [31:0] o_acc_rdata,              // read data, LE
   input wire logic i_ext_valid,                 // external offer
   input wire logic [VEC_W-1:0] i_ext_vector,    // external vector
   input wire logic [PRI_W-1:0] i_ext_prio,      // external priority
   input wire logic [DST_W-1:0] i_ext_dest,      // external target
   input wire logic [NUM_W-1:0] i_ext_num,       // external number
   output logic o_ext_ready,                     // offer taken
   output logic o_irq_valid,                     // interrupt shown
   output logic [VEC_W-1:0] o_irq_vector,        // shown vector
   output logic [PRI_W-1:0] o_irq_prio,          // shown priority
   output logic [DST_W-1:0] o_irq_dest,          // shown target
   output logic [NUM_W-1:0] o_irq_num,           // interrupt number
   output logic [N_CPU-1:0] o_cpu_sel,           // one-hot target
   input wire logic i_irq_ready                  // processor took it
);

   localparam int unsigned IDX_W = (N_SRC > 1) ? $clog2(N_SRC) : 1;

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   // slot index of an address inside the source window
   function automatic logic [IDX_W-1:0] slot_of(input logic [31:0] a);
      logic [31:0] rel;
      rel = a - (DU_BASE + SRC_OFF);
      slot_of = rel[SLOT_SHIFT +: IDX_W];
   endfunction

   // one-hot processor select from a destination number
   function automatic logic [N_CPU-1:0] cpu_onehot(input logic [4:0] d);
      cpu_onehot = '0;
      cpu_onehot[d] = 1'b1;
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [N_SRC-1:0] sync1_r, sync2_r, prev_r, pend_r, pend_nxt;
   logic [N_SRC-1:0] rise, clr;
   logic [VEC_W-1:0] vec_r [N_SRC];
   logic [PRI_W-1:0] pri_r [N_SRC];
   logic [DST_W-1:0] dst_r [N_SRC];
   logic [N_SRC-1:0] msk_r;
   dip_state_t st_r, st_nxt;
   logic valid_nxt, rdy_nxt;
   logic [VEC_W-1:0] vec_nxt;
   logic [PRI_W-1:0] pri_nxt;
   logic [DST_W-1:0] dst_nxt;
   logic [NUM_W-1:0] num_nxt;
   logic [N_CPU-1:0] sel_nxt;
   logic best_found, ext_take;
   logic [IDX_W-1:0] best_idx;
   logic [PRI_W-1:0] best_pri;
   logic in_du, in_su, aligned, cfg_we;
   logic [IDX_W-1:0] acc_slot;
   logic ack_nxt, err_nxt;
   logic [31:0] rdata_nxt;

   // ------------------------------------------------------------
   // input lines: two-flop sync, rising edge sets pending
   // ------------------------------------------------------------
   assign rise = sync2_r & ~prev_r;
   assign pend_nxt = (pend_r & ~clr) | rise;  // set wins over clear

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r <= '0;
         pend_r <= '0;
      end else begin
         sync1_r <= i_irq_lines;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
         pend_r <= pend_nxt;
      end
   end

   // ------------------------------------------------------------
   // address windows of the delivery unit and its group
   // ------------------------------------------------------------
   // group lives at SRC_OFF inside the unit's own window
   always_comb begin
      in_du = (i_acc_addr >= DU_BASE) &&
              (i_acc_addr - DU_BASE < DU_SIZE);
      in_su = (i_acc_addr >= DU_BASE + SRC_OFF) &&
              (i_acc_addr - (DU_BASE + SRC_OFF) <
               SLOT_BYTES * N_SRC);
      aligned = (i_acc_addr[3:0] == SLOT_LOW_ZERO);
      acc_slot = slot_of(i_acc_addr);
      cfg_we = i_acc_valid && i_acc_write && in_su && aligned;
   end

   // answer: ack only inside own window, LE config word on read
   always_comb begin
      ack_nxt = i_acc_valid && in_du;
      err_nxt = i_acc_valid && in_su && !aligned;
      rdata_nxt = ZERO_WORD;
      if (i_acc_valid && !i_acc_write && in_su && aligned) begin
         rdata_nxt[VEC_LSB +: VEC_W] = vec_r[slot_of(i_acc_addr)];
         rdata_nxt[PRI_LSB +: PRI_W] = pri_r[slot_of(i_acc_addr)];
         rdata_nxt[DST_LSB +: DST_W] = dst_r[slot_of(i_acc_addr)];
         rdata_nxt[MSK_BIT] = msk_r[slot_of(i_acc_addr)];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_acc_ack <= 1'b0;
         o_acc_err <= 1'b0;
         o_acc_rdata <= ZERO_WORD;
      end else begin
         o_acc_ack <= ack_nxt;
         o_acc_err <= err_nxt;
         o_acc_rdata <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // source config registers, one 16-byte slot per interrupt
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < N_SRC; g++) begin : g_cfg
         always_ff @(posedge i_core_clk) begin
            if (i_rst) begin
               vec_r[g] <= VEC_RST;
               pri_r[g] <= PRI_RST;
               dst_r[g] <= DST_RST;
               msk_r[g] <= MSK_RST;
            end else if (cfg_we && acc_slot == IDX_W'(g)) begin
               vec_r[g] <= i_acc_wdata[VEC_LSB +: VEC_W];
               pri_r[g] <= i_acc_wdata[PRI_LSB +: PRI_W];
               dst_r[g] <= i_acc_wdata[DST_LSB +: DST_W];
               msk_r[g] <= i_acc_wdata[MSK_BIT];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // pick highest-priority unmasked pending source, lowest wins tie
   // ------------------------------------------------------------
   always_comb begin
      best_found = 1'b0;
      best_idx = '0;
      best_pri = '0;
      for (int i = 0; i < N_SRC; i++) begin
         if (pend_r[i] && !msk_r[i] &&
             (!best_found || pri_r[i] > best_pri)) begin
            best_found = 1'b1;
            best_idx = IDX_W'(i);
            best_pri = pri_r[i];
         end
      end
   end

   // ------------------------------------------------------------
   // delivery: local group vs external unit, shown to processors
   // ------------------------------------------------------------
   // external offer wins only on strictly higher priority
   assign ext_take = i_ext_valid && !o_ext_ready &&
                     (!best_found || i_ext_prio > best_pri);

   always_comb begin
      st_nxt = st_r;
      valid_nxt = o_irq_valid;
      rdy_nxt = 1'b0;
      vec_nxt = o_irq_vector;
      pri_nxt = o_irq_prio;
      dst_nxt = o_irq_dest;
      num_nxt = o_irq_num;
      sel_nxt = o_cpu_sel;
      clr = '0;
      case (st_r)
         ST_IDLE: begin
            if (ext_take) begin
               // values stay on the link until this ready pulse
               vec_nxt = i_ext_vector;
               pri_nxt = i_ext_prio;
               dst_nxt = i_ext_dest;
               num_nxt = i_ext_num;
               sel_nxt = cpu_onehot(i_ext_dest);
               rdy_nxt = 1'b1;
               valid_nxt = 1'b1;
               st_nxt = ST_SHOW;
            end else if (best_found) begin
               vec_nxt = vec_r[best_idx];
               pri_nxt = pri_r[best_idx];
               dst_nxt = dst_r[best_idx];
               num_nxt = GRP_FIRST + NUM_W'(best_idx);
               sel_nxt = cpu_onehot(dst_r[best_idx]);
               clr[best_idx] = 1'b1;
               valid_nxt = 1'b1;
               st_nxt = ST_SHOW;
            end
         end
         ST_SHOW: begin
            if (i_irq_ready) begin
               valid_nxt = 1'b0;
               sel_nxt = '0;
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            valid_nxt = 1'b0;
            sel_nxt = '0;
            st_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         st_r <= ST_IDLE;
         o_irq_valid <= 1'b0;
         o_ext_ready <= 1'b0;
         o_irq_vector <= VEC_RST;
         o_irq_prio <= PRI_RST;
         o_irq_dest <= DST_RST;
         o_irq_num <= '0;
         o_cpu_sel <= '0;
      end else begin
         st_r <= st_nxt;
         o_irq_valid <= valid_nxt;
         o_ext_ready <= rdy_nxt;
         o_irq_vector <= vec_nxt;
         o_irq_prio <= pri_nxt;
         o_irq_dest <= dst_nxt;
         o_irq_num <= num_nxt;
         o_cpu_sel <= sel_nxt;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   pend_set_a: assert property (rise[0] |=> pend_r[0])
      else $error("edge on line 0 did not set pending");
   show_hold_a: assert property (o_irq_valid && !i_irq_ready |=>
      o_irq_valid && $stable(o_irq_vector) && $stable(o_irq_dest))
      else $error("shown interrupt changed before taken");
   idle_quiet_a: assert property (st_r == ST_IDLE |-> !o_irq_valid)
      else $error("valid shown while idle");
   cpu_route_a: assert property (o_irq_valid |->
      $onehot(o_cpu_sel) && o_cpu_sel[o_irq_dest])
      else $error("processor select disagrees with destination");
   ext_pulse_a: assert property (o_ext_ready |->
      o_irq_valid && o_irq_vector == i_ext_vector ##1 !o_ext_ready)
      else $error("external accept not a single matching pulse");
   out_window_a: assert property (i_acc_valid && !in_du |=>
      !o_acc_ack && o_acc_rdata == ZERO_WORD)
      else $error("answer outside own window");
   slot_align_a: assert property (i_acc_valid && in_su && !aligned
      |=> o_acc_err && o_acc_ack)
      else $error("misaligned slot access not flagged");
   cfg_back_a: assert property (cfg_we ##1
      (i_acc_valid && !i_acc_write && $stable(i_acc_addr)) |=>
      o_acc_rdata[VEC_LSB +: VEC_W] == $past(i_acc_wdata[7:0], 2))
      else $error("slot readback differs from written vector");

endmodule // dip_ctrl

// File: core/dip_pkg.sv
// package for the split interrupt controller: slot layout, field
// positions, reset values and delivery state codes.
// assumes a 32-bit register word and at most 32 processors.
package dip_pkg;

   // ------------------------------------------------------------
   // address layout
   // ------------------------------------------------------------
   localparam int unsigned SLOT_SHIFT = 4;            // 16-byte slots
   localparam logic [31:0] SLOT_BYTES = 32'h0000_0010;
   localparam logic [31:0] SRC_OFF = 32'h0001_0000;   // group in window
   localparam logic [3:0] SLOT_LOW_ZERO = 4'h0;

   // ------------------------------------------------------------
   // source config word fields, little-endian byte lanes
   // ------------------------------------------------------------
   localparam int unsigned VEC_LSB = 0;     // byte 0
   localparam int unsigned PRI_LSB = 16;    // byte 2, low nibble
   localparam int unsigned DST_LSB = 24;    // byte 3, low five bits
   localparam int unsigned MSK_BIT = 31;    // byte 3, top bit
   localparam int unsigned VEC_W = 8;
   localparam int unsigned PRI_W = 4;
   localparam int unsigned DST_W = 5;
   localparam int unsigned NUM_W = 8;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] VEC_RST = 8'h00;
   localparam logic [3:0] PRI_RST = 4'h0;
   localparam logic [4:0] DST_RST = 5'h00;
   localparam logic MSK_RST = 1'b1;         // sources start masked
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   // ------------------------------------------------------------
   // delivery state machine
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SHOW = 2'b10
   } dip_state_t;

endpackage // dip_pkg

// File: sim/dip_ext_model.sv
// external source unit model: offers one interrupt over valid/ready.
// assumes the bench starts an offer only when none is outstanding.
`timescale 1ns/1ps

module dip_ext_model (
   input wire logic i_core_clk, // core clock
   input wire logic i_rst, // sync reset, high
   input wire logic i_start, // bench asks for an offer
   input wire logic [24:0] i_data, // number, dest, prio, vector
   input wire logic i_ready, // delivery unit took the offer
   output logic o_valid, // offer standing
   output logic [24:0] o_data // offer fields
);
   // offer held until taken, then scrambled once released
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_valid <= 1'b0;
         o_data <= 25'h0;
      end else if (i_start) begin
         o_valid <= 1'b1;
         o_data <= i_data;
      end else if (o_valid && i_ready) begin
         o_valid <= 1'b0;
         o_data <= ~o_data;
      end
   end
endmodule // dip_ext_model

// File: sim/distributed_interrupt_partitioning_test.sv
// self-checking bench: slot map, alignment, delivery, external link.
// assumes the controller package and the external unit model.
`timescale 1ns/1ps

module distributed_interrupt_partitioning_test;
   import dip_pkg::*;
   localparam logic [31:0] SLOT0 = 32'hFC01_0000;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [15:0] i_irq_lines = 16'h0000;
   logic i_acc_valid = 1'b0;
   logic i_acc_write = 1'b0;
   logic [31:0] i_acc_addr = 32'h0000_0000;
   logic [31:0] i_acc_wdata = 32'h0000_0000;
   logic i_irq_ready = 1'b0;
   logic start = 1'b0;
   logic [24:0] sdata = 25'h0;
   logic o_acc_ack, o_acc_err, o_ext_ready, o_irq_valid, ext_valid;
   logic [31:0] o_acc_rdata, o_cpu_sel;
   logic [7:0] o_irq_vector, o_irq_num;
   logic [3:0] o_irq_prio;
   logic [4:0] o_irq_dest;
   logic [24:0] ext_data;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   int cfg [16];

   always #50 i_core_clk = ~i_core_clk;

   dip_ctrl dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .i_irq_lines(i_irq_lines), .i_acc_valid(i_acc_valid),
      .i_acc_write(i_acc_write), .i_acc_addr(i_acc_addr),
      .i_acc_wdata(i_acc_wdata), .o_acc_ack(o_acc_ack),
      .o_acc_err(o_acc_err), .o_acc_rdata(o_acc_rdata),
      .i_ext_valid(ext_valid), .i_ext_vector(ext_data[7:0]),
      .i_ext_prio(ext_data[11:8]), .i_ext_dest(ext_data[16:12]),
      .i_ext_num(ext_data[24:17]), .o_ext_ready(o_ext_ready),
      .o_irq_valid(o_irq_valid), .o_irq_vector(o_irq_vector),
      .o_irq_prio(o_irq_prio), .o_irq_dest(o_irq_dest),
      .o_irq_num(o_irq_num), .o_cpu_sel(o_cpu_sel),
      .i_irq_ready(i_irq_ready));

   dip_ext_model ext_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .i_start(start), .i_data(sdata), .i_ready(o_ext_ready),
      .o_valid(ext_valid), .o_data(ext_data));

   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   task automatic results;
      if (failures == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one access, answer sampled mid-cycle after the taking edge
   task automatic acc(input logic wr, input logic [31:0] a,
                      input logic [31:0] d);
      @(posedge i_core_clk);
      i_acc_valid <= 1'b1;
      i_acc_write <= wr;
      i_acc_addr <= a;
      i_acc_wdata <= d;
      @(posedge i_core_clk);
      i_acc_valid <= 1'b0;
      @(negedge i_core_clk);
   endtask

   task automatic rd(input logic [31:0] a, input logic [1:0] ae,
                     input logic [31:0] d);
      acc(1'b0, a, 32'h0000_0000);
      chk({30'h0, o_acc_ack, o_acc_err}, {30'h0, ae});
      chk(o_acc_rdata, d);
   endtask

   task automatic wr(input int k, input logic [31:0] w);
      acc(1'b1, SLOT0 + 32'(k) * 32'h10, w);
      chk({31'h0, o_acc_ack}, 32'h1);
      cfg[k] = w & 32'h9F0F_00FF;
   endtask

   task automatic wait_irq;
      int n;
      n = 0;
      while (o_irq_valid !== 1'b1 && n < 40) begin
         @(negedge i_core_clk);
         n++;
      end
      chk({31'h0, o_irq_valid}, 32'h1);
   endtask

   // compare presented fields, then hand them to a processor
   task automatic take(input logic [24:0] e);
      chk({7'h0, o_irq_num, o_irq_dest, o_irq_prio, o_irq_vector},
          {7'h0, e});
      chk(o_cpu_sel, 32'h1 << e[16:12]);
      @(posedge i_core_clk);
      i_irq_ready <= 1'b1;
      @(posedge i_core_clk);
      i_irq_ready <= 1'b0;
      @(negedge i_core_clk);
      chk(o_cpu_sel, 32'h0);
      chk({31'h0, o_irq_valid}, 32'h0);
   endtask

   task automatic pin(input int k);
      @(posedge i_core_clk);
      i_irq_lines[k] <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_irq_lines[k] <= 1'b0;
   endtask

   function automatic logic [24:0] fld(input int k);
      return {8'(k), cfg[k][28:24], cfg[k][19:16], cfg[k][7:0]};
   endfunction

   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         results();
      end
   end

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      int k;
      logic [24:0] e;
      void'($urandom(32'hAC8C));
      repeat (16) @(posedge i_core_clk);
      i_rst <= 1'b0;
      for (int i = 0; i < 16; i++)
         rd(SLOT0 + 32'(i) * 32'h10, 2'b10, 32'h8000_0000);
      for (int i = 0; i < 16; i++)
         wr(i, $urandom);
      for (int i = 0; i < 16; i++)
         rd(SLOT0 + 32'(i) * 32'h10, 2'b10, cfg[i]);
      acc(1'b1, SLOT0 + 32'h8, 32'hFFFF_FFFF);
      chk({30'h0, o_acc_ack, o_acc_err}, 32'h3);
      rd(SLOT0, 2'b10, cfg[0]);
      rd(SLOT0 + 32'h4, 2'b11, 32'h0000_0000);
      rd(SLOT0 + 32'h100, 2'b10, 32'h0000_0000);
      rd(32'hFC00_0010, 2'b10, 32'h0000_0000);
      rd(32'hFC04_0000, 2'b00, 32'h0000_0000);
      rd(32'hFBFF_FFF0, 2'b00, 32'h0000_0000);
      // back-to-back write then read of one slot, strobe held high
      @(posedge i_core_clk);
      i_acc_valid <= 1'b1;
      i_acc_write <= 1'b1;
      i_acc_addr <= SLOT0 + 32'h50;
      i_acc_wdata <= 32'h8A05_00C3;
      @(posedge i_core_clk);
      i_acc_write <= 1'b0;
      @(posedge i_core_clk);
      i_acc_valid <= 1'b0;
      @(negedge i_core_clk);
      chk(o_acc_rdata, 32'h8A05_00C3);
      for (int i = 0; i < 16; i++)
         wr(i, 32'h8000_0000);
      // single local sources, edge slots first
      for (int i = 0; i < 6; i++) begin
         k = (i == 0) ? 0 : (i == 1) ? 15 : int'($urandom % 16);
         wr(k, $urandom & 32'h1F0F_00FF);
         pin(k);
         wait_irq();
         take(fld(k));
         wr(k, 32'h8000_0000);
      end
      // two locals at once: higher priority, then lower index on a tie
      for (int t = 0; t < 2; t++) begin
         wr(3, 32'h0203_0011);
         wr(9, t ? 32'h0503_0022 : 32'h0509_0022);
         fork
            pin(3);
            pin(9);
         join
         wait_irq();
         take(fld(t ? 3 : 9));
         wait_irq();
         take(fld(t ? 9 : 3));
         wr(3, 32'h8000_0000);
         wr(9, 32'h8000_0000);
      end
      // external offer must wait while a local one is shown
      wr(2, 32'h010F_0044);
      wr(6, 32'h0103_0066);
      fork
         pin(2);
         pin(6);
      join
      wait_irq();
      e = {8'h40, 5'($urandom), 4'h3, 8'($urandom)};
      @(posedge i_core_clk);
      start <= 1'b1;
      sdata <= e;
      @(posedge i_core_clk);
      start <= 1'b0;
      repeat (3) begin
         @(negedge i_core_clk);
         chk({31'h0, o_ext_ready}, 32'h0);
      end
      take(fld(2));
      // equal external priority loses to the pending local source
      wait_irq();
      chk({31'h0, o_ext_ready}, 32'h0);
      take(fld(6));
      wait_irq();
      chk({31'h0, o_ext_ready}, 32'h1);
      take(e);
      chk({31'h0, ext_valid}, 32'h0);
      results();
   end
endmodule // distributed_interrupt_partitioning_test
